// ==== src/gsd_decoder.sv ====
// geometry stage state packet decoder, vertex gather and bypass
// assumes command dwords and vertices arrive synchronous to clk_sys
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "gsd_params.svh"

module gsd_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command stream
  input wire logic cmdValid,
  input wire logic [31:0] cmdData,
  output logic cmdReady,
  output logic cmdError,
  // upstream vertices
  input wire logic vtxInValid,
  input wire gsd_pkg::gsd_vertex_t vtxIn,
  output logic vtxInReady,
  // downstream vertices
  output logic vtxOutValid,
  output gsd_pkg::gsd_vertex_t vtxOut,
  output logic [5:0] vtxOutTopology,
  input wire logic vtxOutReady,
  // thread dispatch
  output logic threadValid,
  output logic [127:0] threadVerts [4],
  output logic [2:0] threadVertCount,
  output logic [31:0] threadScratchAddr,
  output gsd_pkg::gsd_state_t threadState,
  input wire logic threadReady,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata
);
  gsd_pkg::gsd_parse_t parseReg, parseNext;
  logic [7:0] remainReg, remainNext;
  logic [2:0] idxReg, idxNext;
  gsd_pkg::gsd_state_t stateReg, stateNext;
  logic errReg, errNext;
  logic enableReg, enableNext;
  logic [127:0] gatherReg [4];
  logic [127:0] gatherNext [4];
  logic [2:0] gcountReg, gcountNext;
  logic tvalidReg, tvalidNext;
  logic [127:0] tvertReg [4];
  logic [127:0] tvertNext [4];
  logic [2:0] tcountReg, tcountNext;
  logic [31:0] tscratchReg, tscratchNext;
  logic [6:0] tslotReg, tslotNext;
  logic ovalidReg, ovalidNext;
  gsd_pkg::gsd_vertex_t odataReg, odataNext;
  logic [31:0] rdataReg, rdataNext;
  logic [15:0] dispatchCntReg, dispatchCntNext;

  function automatic logic headerOk(input logic [31:0] d);
    headerOk = d[31:29] == `GSD_CMD_TYPE && d[28:27] == `GSD_CMD_SUBTYPE &&
      d[26:24] == `GSD_CMD_OPCODE && d[23:16] == `GSD_CMD_SUBOP;
  endfunction

  // 1 KB units times two to the field; field is capped at its valid top
  function automatic logic [31:0] scratchBytes(input logic [3:0] f);
    logic [3:0] s;
    s = (f > `GSD_SCRATCH_MAX) ? `GSD_SCRATCH_MAX : f;
    scratchBytes = 32'h0000_0400 << s;
  endfunction

  assign cmdReady = 1'b1;
  assign cmdError = errReg;

  always_comb begin
    parseNext = parseReg;
    remainNext = remainReg;
    idxNext = idxReg;
    stateNext = stateReg;
    errNext = errReg;
    if (cmdValid) begin
      case (parseReg)
        gsd_pkg::ST_IDLE: begin
          remainNext = cmdData[7:0] + 8'h01;
          idxNext = 3'h1;
          if (headerOk(cmdData)) begin
            parseNext = gsd_pkg::ST_BODY;
            errNext = 1'b0;
          end else begin
            parseNext = gsd_pkg::ST_SKIP;
            errNext = 1'b1;
          end
        end
        gsd_pkg::ST_BODY: begin
          case (idxReg)
            3'h1: stateNext.kernelPtr = cmdData[31:6];
            3'h2: begin
              stateNext.singleFlowMode = cmdData[31];
              stateNext.maskSourceSelect = cmdData[31] ? 1'b0 : cmdData[30];
              stateNext.samplerHint = (cmdData[29:27] > `GSD_SAMPLER_MAX) ?
                3'h0 : cmdData[29:27];
              stateNext.bindingCount = cmdData[25:18];
              stateNext.highPriority = cmdData[17];
              stateNext.altFloatMode = cmdData[16];
              stateNext.threadControlRegister = 32'h0;
              stateNext.threadControlRegister[12] = cmdData[13];
              stateNext.threadControlRegister[11] = cmdData[11];
              stateNext.threadControlRegister[13] = cmdData[7];
            end
            3'h3: begin
              stateNext.scratchBase = cmdData[31:10];
              stateNext.scratchSizeLog = cmdData[3:0];
            end
            3'h4: begin
              stateNext.outVertexSize = cmdData[28:23];
              stateNext.primitiveTopologyCode = cmdData[22:17];
              stateNext.vertexReadLength = cmdData[16:11];
              stateNext.includeHandles = cmdData[10];
            end
            default: ;
          endcase
          if (idxReg != 3'h7) idxNext = idxReg + 3'h1;
          remainNext = remainReg - 8'h01;
          if (remainReg == 8'h01) parseNext = gsd_pkg::ST_IDLE;
        end
        gsd_pkg::ST_SKIP: begin
          remainNext = remainReg - 8'h01;
          if (remainReg == 8'h01) parseNext = gsd_pkg::ST_IDLE;
        end
        default: parseNext = gsd_pkg::ST_IDLE;
      endcase
    end
  end

  // vertex path: a single output stage serves bypass, gather feeds dispatch
  logic outFree, thrFree, takeVtx;
  assign outFree = !ovalidReg || vtxOutReady;
  assign thrFree = !tvalidReg || threadReady;
  assign vtxInReady = enableReg ? thrFree : outFree;
  assign takeVtx = vtxInValid && vtxInReady;

  always_comb begin
    ovalidNext = ovalidReg && !vtxOutReady;
    odataNext = odataReg;
    gatherNext = gatherReg;
    gcountNext = gcountReg;
    tvalidNext = tvalidReg && !threadReady;
    tvertNext = tvertReg;
    tcountNext = tcountReg;
    tscratchNext = tscratchReg;
    tslotNext = tslotReg;
    dispatchCntNext = dispatchCntReg;
    if (takeVtx && !enableReg) begin
      ovalidNext = 1'b1;
      odataNext = vtxIn;
    end
    if (takeVtx && enableReg) begin
      gatherNext[gcountReg[1:0]] = vtxIn.data;
      // an object longer than four vertices is cut into four-vertex groups
      if (vtxIn.lastOfObject || gcountReg == 3'h3) begin
        tvalidNext = 1'b1;
        tvertNext = gatherNext;
        tcountNext = gcountReg + 3'h1;
        gcountNext = 3'h0;
        // each of 128 successive threads gets its own slice of the scratch area
        tscratchNext = {stateReg.scratchBase, 10'h0} +
          scratchBytes(stateReg.scratchSizeLog) * {25'h0, tslotReg};
        tslotNext = tslotReg + 7'h1;
        dispatchCntNext = dispatchCntReg + 16'h1;
      end else begin
        gcountNext = gcountReg + 3'h1;
      end
    end
  end

  always_comb begin
    enableNext = enableReg;
    rdataNext = 32'h0;
    if (regWrite && regAddr == `GSD_REG_ENABLE) enableNext = regWdata[0];
    if (regRead) begin
      case (regAddr)
        `GSD_REG_ENABLE: rdataNext = {31'h0, enableReg};
        `GSD_REG_STATUS: rdataNext = {dispatchCntReg, 13'h0, gcountReg};
        `GSD_REG_KERNEL: rdataNext = {stateReg.kernelPtr, 6'h0};
        `GSD_REG_CTRL: rdataNext = stateReg.threadControlRegister;
        `GSD_REG_SCRATCH: rdataNext = {stateReg.scratchBase, 6'h0, stateReg.scratchSizeLog};
        `GSD_REG_OUTPUT: rdataNext = {3'h0, stateReg.outVertexSize,
          stateReg.primitiveTopologyCode, stateReg.vertexReadLength,
          stateReg.includeHandles, 10'h0};
        default: rdataNext = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      parseReg <= gsd_pkg::ST_IDLE;
      remainReg <= 8'h0;
      idxReg <= 3'h0;
      stateReg <= '0;
      errReg <= 1'b0;
      enableReg <= 1'b0;
      gatherReg <= '{default: 128'h0};
      gcountReg <= 3'h0;
      tvalidReg <= 1'b0;
      tvertReg <= '{default: 128'h0};
      tcountReg <= 3'h0;
      tscratchReg <= 32'h0;
      tslotReg <= 7'h0;
      ovalidReg <= 1'b0;
      odataReg <= '0;
      rdataReg <= 32'h0;
      dispatchCntReg <= 16'h0;
    end else begin
      parseReg <= parseNext;
      remainReg <= remainNext;
      idxReg <= idxNext;
      stateReg <= stateNext;
      errReg <= errNext;
      enableReg <= enableNext;
      gatherReg <= gatherNext;
      gcountReg <= gcountNext;
      tvalidReg <= tvalidNext;
      tvertReg <= tvertNext;
      tcountReg <= tcountNext;
      tscratchReg <= tscratchNext;
      tslotReg <= tslotNext;
      ovalidReg <= ovalidNext;
      odataReg <= odataNext;
      rdataReg <= rdataNext;
      dispatchCntReg <= dispatchCntNext;
    end
  end

  assign vtxOutValid = ovalidReg;
  assign vtxOut = odataReg;
  assign vtxOutTopology = stateReg.primitiveTopologyCode;
  assign threadValid = tvalidReg;
  assign threadVerts = tvertReg;
  assign threadVertCount = tcountReg;
  assign threadScratchAddr = tscratchReg;
  assign threadState = stateReg;
  assign regRdata = rdataReg;

  property p_hdr_error;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmdValid && parseReg == gsd_pkg::ST_IDLE && !headerOk(cmdData)) |=> cmdError;
  endproperty
  a_hdr_error: assert property (p_hdr_error) else $error("bad header not flagged");

  property p_len;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmdValid && parseReg == gsd_pkg::ST_IDLE && headerOk(cmdData) && cmdData[7:0] == 8'h0)
      ##1 cmdValid |=> parseReg == gsd_pkg::ST_IDLE;
  endproperty
  a_len: assert property (p_len) else $error("packet length wrong");

  property p_kernel;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmdValid && parseReg == gsd_pkg::ST_BODY && idxReg == 3'h1)
      |=> stateReg.kernelPtr == $past(cmdData[31:6]);
  endproperty
  a_kernel: assert property (p_kernel) else $error("kernel pointer not taken");

  property p_mask;
    @(posedge clk_sys) disable iff (!rst_n)
      stateReg.singleFlowMode |-> !stateReg.maskSourceSelect;
  endproperty
  a_mask: assert property (p_mask) else $error("mask source used in single flow");

  property p_sampler;
    @(posedge clk_sys) disable iff (!rst_n) stateReg.samplerHint <= `GSD_SAMPLER_MAX;
  endproperty
  a_sampler: assert property (p_sampler) else $error("reserved sampler hint kept");

  property p_ctrl;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmdValid && parseReg == gsd_pkg::ST_BODY && idxReg == 3'h2) |=>
      threadState.threadControlRegister[13:11] == {$past(cmdData[7]), $past(cmdData[13]),
      $past(cmdData[11])};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("exception enables misplaced");

  sequence s_bypass_in;
    vtxInValid && vtxInReady && !enableReg;
  endsequence
  property p_bypass;
    @(posedge clk_sys) disable iff (!rst_n)
      s_bypass_in |=> vtxOutValid && vtxOut == $past(vtxIn);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass vertex altered");

  property p_gather;
    @(posedge clk_sys) disable iff (!rst_n)
      (takeVtx && enableReg && vtxIn.lastOfObject) |=> threadValid && !$rose(vtxOutValid);
  endproperty
  a_gather: assert property (p_gather) else $error("object not dispatched");

  property p_topo;
    @(posedge clk_sys) disable iff (!rst_n) vtxOutValid |-> vtxOutTopology ==
      stateReg.primitiveTopologyCode;
  endproperty
  a_topo: assert property (p_topo) else $error("topology not attached");
endmodule // gsd_decoder

// ==== src/gsd_params.svh ====
// constants for the geometry stage state decoder: packet fields and codes
// assumes a 32-bit dword command stream
`ifndef GSD_PARAMS_SVH
`define GSD_PARAMS_SVH
`define GSD_CMD_TYPE 3'h3
`define GSD_CMD_SUBTYPE 2'h3
`define GSD_CMD_OPCODE 3'h0
`define GSD_CMD_SUBOP 8'h11
`define GSD_LEN_BIAS 8'h02
`define GSD_SAMPLER_MAX 3'h4
`define GSD_SCRATCH_MAX 4'hb
`define GSD_VSIZE_MAX 6'h3e
`define GSD_REG_ENABLE 4'h0
`define GSD_REG_STATUS 4'h1
`define GSD_REG_KERNEL 4'h2
`define GSD_REG_CTRL 4'h3
`define GSD_REG_SCRATCH 4'h4
`define GSD_REG_OUTPUT 4'h5
`endif

// ==== src/gsd_pkg.sv ====
// types for the geometry stage state decoder
// assumes gsd_params.svh supplies the numeric constants
package gsd_pkg;
  typedef struct packed {
    logic [25:0] kernelPtr;
    logic singleFlowMode;
    logic maskSourceSelect;
    logic [2:0] samplerHint;
    logic [7:0] bindingCount;
    logic highPriority;
    logic altFloatMode;
    logic [31:0] threadControlRegister;
    logic [21:0] scratchBase;
    logic [3:0] scratchSizeLog;
    logic [5:0] outVertexSize;
    logic [5:0] primitiveTopologyCode;
    logic [5:0] vertexReadLength;
    logic includeHandles;
  } gsd_state_t;
  typedef struct packed {
    logic [127:0] data;
    logic lastOfObject;
  } gsd_vertex_t;
  typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_SKIP} gsd_parse_t;
endpackage

// ==== tb/gsd_stream_model.sv ====
// command streamer and upstream stage model for the state decoder
// assumes the bench calls its tasks just after a rising edge of clk_sys
`timescale 1ns/1ps
module gsd_stream_model (
  // clock
  input wire logic clk_sys,
  // command stream
  output logic cmdValid,
  output logic [31:0] cmdData,
  // upstream vertices
  output logic vtxInValid,
  output gsd_pkg::gsd_vertex_t vtxIn,
  input wire logic vtxInReady
);
  initial begin
    cmdValid = 1'b0;
    cmdData = 32'h0;
    vtxInValid = 1'b0;
    vtxIn = '0;
  end
  // dwords go back to back; a released bus shows the inverse so stale data never looks valid
  task automatic send_dword(input logic [31:0] d, input logic last);
    cmdValid <= 1'b1;
    cmdData <= d;
    @(posedge clk_sys);
    if (last) begin
      cmdValid <= 1'b0;
      cmdData <= ~d;
    end
  endtask
  // holds the vertex until taken, then idles one cycle
  task automatic send_vertex(input logic [127:0] d, input logic last);
    int n;
    n = 0;
    vtxInValid <= 1'b1;
    vtxIn <= {d, last};
    do begin
      @(posedge clk_sys);
      n++;
    end while (vtxInReady !== 1'b1 && n < 50);
    vtxInValid <= 1'b0;
    vtxIn <= {~d, ~last};
    @(posedge clk_sys);
  endtask
endmodule // gsd_stream_model

// ==== tb/test_gsd_decoder.sv ====
// self-checking bench for the geometry stage state decoder
// assumes gsd_stream_model feeds commands and upstream vertices
`timescale 1ns/1ps
module test_gsd_decoder;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid, cmdReady, cmdError, vtxInValid, vtxInReady, vtxOutValid, vtxOutReady;
  logic threadValid, threadReady, regWrite, regRead;
  logic [31:0] cmdData, threadScratchAddr, regWdata, regRdata, rd;
  logic [127:0] threadVerts [4];
  logic [5:0] vtxOutTopology;
  logic [2:0] threadVertCount;
  logic [3:0] regAddr;
  gsd_pkg::gsd_vertex_t vtxIn, vtxOut;
  gsd_pkg::gsd_state_t threadState;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  localparam logic [31:0] HDR = 32'h78110005;
  localparam logic [31:0] D3 = {22'h5, 6'h0, 4'h2};
  localparam logic [31:0] D4 = {3'h0, 6'h3d, 6'h15, 6'h04, 1'b1, 10'h0};

  always #12.5 clk_sys = ~clk_sys;

  gsd_decoder i_dut (.clk_sys, .rst_n, .cmdValid, .cmdData, .cmdReady, .cmdError,
    .vtxInValid, .vtxIn, .vtxInReady, .vtxOutValid, .vtxOut, .vtxOutTopology, .vtxOutReady,
    .threadValid, .threadVerts, .threadVertCount, .threadScratchAddr, .threadState,
    .threadReady, .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
  gsd_stream_model i_src (.clk_sys, .cmdValid, .cmdData, .vtxInValid, .vtxIn, .vtxInReady);

  task automatic printVerdict;
    if (badCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the whole run is under a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      printVerdict;
    end
  end
  task automatic check(input string what, input logic [128:0] seen, input logic [128:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
    rd = regRdata;
  endtask
  // body carries length+1 dwords; trailing dwords are filler the decoder must ignore
  task automatic send_pkt(input logic [31:0] h, d1, d2, d3, d4);
    logic [31:0] body [6];
    body = '{d1, d2, d3, d4, 32'hffffffff, 32'hffffffff};
    i_src.send_dword(h, 1'b0);
    for (int i = 0; i <= h[7:0]; i++) i_src.send_dword(body[i], i == h[7:0]);
    @(posedge clk_sys);
  endtask
  task automatic wait_valid(input bit thr);
    int n;
    n = 0;
    while ((thr ? threadValid : vtxOutValid) !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check("output valid", n < 20, 1'b1);
  endtask
  task automatic pulse_ready(input bit thr);
    if (thr) threadReady <= 1'b1;
    else vtxOutReady <= 1'b1;
    @(posedge clk_sys);
    threadReady <= 1'b0;
    vtxOutReady <= 1'b0;
  endtask

  task automatic t_reset;
    check("cmdReady", cmdReady, 1'b1);
    check("vtxInReady", vtxInReady, 1'b1);
    reg_rd(4'h0);
    check("enable reg", rd, 32'h0);
    reg_rd(4'hf);
    check("unmapped reg", rd, 32'h0);
  endtask
  task automatic t_state;
    send_pkt(HDR, 32'h123456ff,
      {2'b01, 3'h4, 1'b0, 8'ha5, 2'b11, 2'b0, 3'b100, 3'b0, 1'b1, 7'h0}, D3, D4);
    check("error flag", cmdError, 1'b0);
    reg_rd(4'h2);
    check("kernel reg", rd, 32'h123456c0);
    check("mask select", threadState.maskSourceSelect, 1'b1);
    check("sampler hint", threadState.samplerHint, 3'h4);
    check("binding count", threadState.bindingCount, 8'ha5);
    check("float mode", threadState.altFloatMode, 1'b1);
    check("ctrl bits", threadState.threadControlRegister[13:11], 3'b110);
    check("scratch base", threadState.scratchBase, 22'h5);
    check("scratch size", threadState.scratchSizeLog, 4'h2);
    check("vertex size", threadState.outVertexSize, 6'h3d);
    check("topology", threadState.primitiveTopologyCode, 6'h15);
    check("read length", threadState.vertexReadLength, 6'h04);
    check("handles", threadState.includeHandles, 1'b1);
    reg_rd(4'h5);
    check("output reg", rd, D4);
    reg_rd(4'h3);
    check("control reg", rd, 32'h00003000);
    reg_rd(4'h4);
    check("scratch reg", rd, D3);
  endtask
  task automatic t_bad;
    send_pkt(32'h79110001, 32'hffffffc0, 32'h0, 32'h0, 32'h0);
    check("bad header flag", cmdError, 1'b1);
    check("kernel kept", threadState.kernelPtr, 32'h123456ff >> 6);
    send_pkt(32'h78110000, 32'h80, 32'h0, 32'h0, 32'h0);
    check("short packet kernel", threadState.kernelPtr, 26'h2);
    send_pkt(HDR, 32'h40, {2'b11, 3'h5, 1'b0, 8'h0, 4'h0, 3'b001, 3'b0, 1'b0, 7'h0}, D3, D4);
    check("error cleared", cmdError, 1'b0);
    check("kernel new", threadState.kernelPtr, 26'h1);
    check("mask ignored", threadState.maskSourceSelect, 1'b0);
    check("sampler reserved", threadState.samplerHint, 3'h0);
    check("ctrl bits b", threadState.threadControlRegister[13:11], 3'b001);
  endtask
  task automatic t_bypass;
    i_src.send_vertex(128'hcafe, 1'b1);
    wait_valid(1'b0);
    check("bypass vertex", vtxOut, {128'hcafe, 1'b1});
    check("bypass topology", vtxOutTopology, 6'h15);
    pulse_ready(1'b0);
  endtask
  task automatic t_gather;
    reg_wr(4'h0, 32'h1);
    for (int i = 1; i <= 3; i++) i_src.send_vertex(128'(i), i == 3);
    wait_valid(1'b1);
    check("vertex count", threadVertCount, 3'h3);
    for (int i = 0; i < 3; i++) check("thread vertex", threadVerts[i], 128'(i + 1));
    check("no bypass", vtxOutValid, 1'b0);
    check("scratch slot 0", threadScratchAddr, 32'h1400);
    pulse_ready(1'b1);
    i_src.send_vertex(128'h9, 1'b1);
    wait_valid(1'b1);
    check("single vertex", threadVertCount, 3'h1);
    check("scratch slot 1", threadScratchAddr, 32'h2400);
    pulse_ready(1'b1);
    reg_rd(4'h1);
    check("status reg", rd, 32'h00020000);
  endtask

  initial begin
    regAddr = 4'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    vtxOutReady = 1'b0;
    threadReady = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_state;
    t_bad;
    t_bypass;
    t_gather;
    printVerdict;
  end
endmodule // test_gsd_decoder
